// File: core/card_debug_uart.sv
// Card debug serial port: data, control/status and rate registers on the
// local bus, 8N1 transmit and receive lines.
// Assumes a 100 MHz clock, synchronous reset and a serial input already
// synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "card_uart_defs.svh"
module card_debug_uart #(
  parameter int FIFO_DEPTH = `UART_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Local register port
  input wire logic [`UART_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic txReady,
  // Serial lines
  output logic txLine,
  input wire logic rxLine
);
  // ****************************************
  // Reference tick and divisor
  // ****************************************
  localparam logic [7:0] REF_DIV = 8'(`UART_REF_DIV);
  logic [7:0] refCnt_q, refCnt_d;
  logic refTick;
  logic [7:0] rate_q, rate_d, effDiv;

  assign refTick = (refCnt_q == REF_DIV - 8'h01);
  // A zero divisor would give 256-tick transmit bits and per-tick receive samples, so it runs as one
  assign effDiv = (rate_q == 8'h00) ? 8'h01 : rate_q;

  always_comb
  begin
    refCnt_d = refTick ? 8'h00 : refCnt_q + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      refCnt_q <= 8'h00;
    else
      refCnt_q <= refCnt_d;
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0] intEn_q, intEn_d;
  logic [7:0] rdData_d;
  logic [7:0] rxData_q, rxData_d;
  logic rxAvail_q, rxAvail_d;
  logic rxDone;
  logic [7:0] rxShift_q, rxShift_d;
  logic txBusy;
  logic fifoValid, fifoPop;
  logic [7:0] fifoData;
  logic wrData, wrCtrl, wrRate, rdDataReg;

  assign wrData = regWrEn && (regAddr == `UART_ADDR_DATA);
  assign wrCtrl = regWrEn && (regAddr == `UART_ADDR_CTRL);
  assign wrRate = regWrEn && (regAddr == `UART_ADDR_RATE);
  assign rdDataReg = regRdEn && (regAddr == `UART_ADDR_DATA);

  always_comb
  begin
    intEn_d = intEn_q;
    rate_d = rate_q;
    rxData_d = rxData_q;
    rxAvail_d = rxAvail_q;
    rdData_d = regRdData;
    // Only the enables take write data here; status bits ignore it
    if (wrCtrl)
      intEn_d = {regWrData[`UART_BIT_EN_TX_INT], regWrData[`UART_BIT_EN_RX_INT]};
    if (wrRate)
      rate_d = regWrData;
    if (rdDataReg)
      rxAvail_d = 1'b0;
    // A character landing on the clearing read still counts
    if (rxDone)
    begin
      rxData_d = rxShift_q;
      rxAvail_d = 1'b1;
    end
    if (regRdEn)
    begin
      if (regAddr == `UART_ADDR_DATA)
        rdData_d = rxData_q;
      else if (regAddr == `UART_ADDR_CTRL)
        rdData_d = {intEn_q, 4'h0, rxAvail_q, txBusy};
      else if (regAddr == `UART_ADDR_RATE)
        rdData_d = rate_q;
      else
        rdData_d = 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      intEn_q <= `UART_EN_RST;
      rate_q <= `UART_RATE_RST;
      rxData_q <= 8'h00;
      rxAvail_q <= 1'b0;
      regRdData <= 8'h00;
    end
    else
    begin
      intEn_q <= intEn_d;
      rate_q <= rate_d;
      rxData_q <= rxData_d;
      rxAvail_q <= rxAvail_d;
      regRdData <= rdData_d;
    end
  end

  // ****************************************
  // Transmit queue
  // ****************************************
  // Writes made while the queue is full are dropped; txReady warns of it
  uart_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) txFifo (
    .clk(clk),
    .srst(srst),
    .inValid(wrData),
    .inReady(txReady),
    .inData(regWrData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  // ****************************************
  // Transmitter
  // ****************************************
  card_uart_pkg::tx_state_t txState_q, txState_d;
  logic [7:0] txRef_q, txRef_d, txShift_q, txShift_d;
  logic [2:0] txBit_q, txBit_d;
  logic txLine_d, txBitEnd;

  assign txBitEnd = refTick && (txRef_q + 8'h01 == effDiv);
  assign fifoPop = (txState_q == card_uart_pkg::TX_IDLE) && fifoValid;
  // Queued bytes count as sending so software sees one busy stretch
  assign txBusy = (txState_q != card_uart_pkg::TX_IDLE) || fifoValid;

  always_comb
  begin
    txState_d = txState_q;
    txRef_d = txRef_q;
    txShift_d = txShift_q;
    txBit_d = txBit_q;
    txLine_d = txLine;
    if (txState_q != card_uart_pkg::TX_IDLE && refTick)
      txRef_d = txBitEnd ? 8'h00 : txRef_q + 8'h01;
    unique case (txState_q)
      card_uart_pkg::TX_IDLE:
        if (fifoValid)
        begin
          txShift_d = fifoData;
          txRef_d = 8'h00;
          txLine_d = 1'b0;
          txState_d = card_uart_pkg::TX_START;
        end
      card_uart_pkg::TX_START:
        if (txBitEnd)
        begin
          txLine_d = txShift_q[0];
          txBit_d = 3'h0;
          txState_d = card_uart_pkg::TX_DATA;
        end
      card_uart_pkg::TX_DATA:
        if (txBitEnd)
        begin
          txShift_d = {1'b0, txShift_q[7:1]};
          txBit_d = txBit_q + 3'h1;
          txLine_d = (txBit_q == 3'h7) ? 1'b1 : txShift_q[1];
          if (txBit_q == 3'h7)
            txState_d = card_uart_pkg::TX_STOP;
        end
      card_uart_pkg::TX_STOP:
        if (txBitEnd)
          txState_d = card_uart_pkg::TX_IDLE;
      default:
        txState_d = card_uart_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txState_q <= card_uart_pkg::TX_IDLE;
      txRef_q <= 8'h00;
      txShift_q <= 8'h00;
      txBit_q <= 3'h0;
      txLine <= 1'b1;
    end
    else
    begin
      txState_q <= txState_d;
      txRef_q <= txRef_d;
      txShift_q <= txShift_d;
      txBit_q <= txBit_d;
      txLine <= txLine_d;
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  card_uart_pkg::rx_state_t rxState_q, rxState_d;
  logic [7:0] rxRef_q, rxRef_d, rxTarget;
  logic [2:0] rxBit_q, rxBit_d;
  logic rxSample;

  // Start bit is checked at mid-bit, then every full bit after that
  assign rxTarget = (rxState_q == card_uart_pkg::RX_START) ? {1'b0, effDiv[7:1]} : effDiv;
  assign rxSample = refTick && (rxRef_q + 8'h01 >= rxTarget);
  assign rxDone = rxSample && (rxState_q == card_uart_pkg::RX_STOP) && rxLine;

  always_comb
  begin
    rxState_d = rxState_q;
    rxRef_d = rxRef_q;
    rxShift_d = rxShift_q;
    rxBit_d = rxBit_q;
    if (rxState_q != card_uart_pkg::RX_IDLE && refTick)
      rxRef_d = rxSample ? 8'h00 : rxRef_q + 8'h01;
    unique case (rxState_q)
      card_uart_pkg::RX_IDLE:
        if (!rxLine)
        begin
          rxRef_d = 8'h00;
          rxState_d = card_uart_pkg::RX_START;
        end
      card_uart_pkg::RX_START:
        if (rxSample)
        begin
          rxBit_d = 3'h0;
          // A glitch shorter than half a bit is not a start bit
          rxState_d = rxLine ? card_uart_pkg::RX_IDLE : card_uart_pkg::RX_DATA;
        end
      card_uart_pkg::RX_DATA:
        if (rxSample)
        begin
          rxShift_d = {rxLine, rxShift_q[7:1]};
          rxBit_d = rxBit_q + 3'h1;
          if (rxBit_q == 3'h7)
            rxState_d = card_uart_pkg::RX_STOP;
        end
      card_uart_pkg::RX_STOP:
        // A low stop bit drops the character
        if (rxSample)
          rxState_d = card_uart_pkg::RX_IDLE;
      default:
        rxState_d = card_uart_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rxState_q <= card_uart_pkg::RX_IDLE;
      rxRef_q <= 8'h00;
      rxShift_q <= 8'h00;
      rxBit_q <= 3'h0;
    end
    else
    begin
      rxState_q <= rxState_d;
      rxRef_q <= rxRef_d;
      rxShift_q <= rxShift_d;
      rxBit_q <= rxBit_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Clocks within a tx bit, counted apart from the divider so bitRate_a is independent
  logic [15:0] bitClk_q, bitClk_d, bitLen;

  assign bitLen = 16'(effDiv) * 16'(`UART_REF_DIV);

  always_comb
  begin
    bitClk_d = bitClk_q + 16'h0001;
    if (txBitEnd || txState_q == card_uart_pkg::TX_IDLE)
      bitClk_d = 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      bitClk_q <= 16'h0000;
    else
      bitClk_q <= bitClk_d;
  end

  sequence txFrameStart;
    txState_q == card_uart_pkg::TX_IDLE && fifoValid;
  endsequence

  sequence txStartBitLow;
    txState_q == card_uart_pkg::TX_START && !txLine && txBusy;
  endsequence

  txLoad_a: assert property (@(posedge clk) disable iff (srst)
    wrData && txReady |=> txBusy)
    else $error("queued byte did not make the port busy");

  rxRead_a: assert property (@(posedge clk) disable iff (srst)
    rdDataReg |=> regRdData == $past(rxData_q))
    else $error("data read did not return last received byte");

  rxFlag_a: assert property (@(posedge clk) disable iff (srst)
    rxDone |=> rxAvail_q && rxData_q == $past(rxShift_q))
    else $error("received byte not flagged");

  txBusyFrame_a: assert property (@(posedge clk) disable iff (srst)
    txFrameStart |=> txStartBitLow)
    else $error("start bit not sent or busy low");

  intEnStore_a: assert property (@(posedge clk) disable iff (srst)
    wrCtrl |=> intEn_q == $past({regWrData[7], regWrData[6]}))
    else $error("interrupt enables not stored");

  statusRo_a: assert property (@(posedge clk) disable iff (srst)
    wrCtrl && !rxDone && !rdDataReg |=> rxAvail_q == $past(rxAvail_q))
    else $error("status flag changed by a write");

  bitRate_a: assert property (@(posedge clk) disable iff (srst)
    txBitEnd && (txState_q == card_uart_pkg::TX_DATA || txState_q == card_uart_pkg::TX_STOP)
    |-> bitClk_q == bitLen - 16'h0001)
    else $error("bit period differs from divisor");

  stopHigh_a: assert property (@(posedge clk) disable iff (srst)
    txState_q == card_uart_pkg::TX_STOP |-> txLine)
    else $error("stop bit not high");

  readClear_a: assert property (@(posedge clk) disable iff (srst)
    rdDataReg && !rxDone |=> !rxAvail_q)
    else $error("receive flag not cleared by read");
endmodule
`default_nettype wire

// File: core/card_uart_defs.svh
// Constants of the card debug serial port: offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from core/ files.
`ifndef CARD_UART_DEFS_SVH
`define CARD_UART_DEFS_SVH

// ****************************************
// Register offsets (local word addresses)
// ****************************************
`define UART_ADDR_W 24
`define UART_ADDR_DATA 24'h040048
`define UART_ADDR_CTRL 24'h040049
`define UART_ADDR_RATE 24'h04004A

// ****************************************
// Control/status fields
// ****************************************
`define UART_BIT_TX_BUSY 0
`define UART_BIT_RX_READY 1
`define UART_BIT_EN_RX_INT 6
`define UART_BIT_EN_TX_INT 7

// ****************************************
// Reset values
// ****************************************
`define UART_RATE_RST 8'hD0
`define UART_EN_RST 2'h0

// ****************************************
// Timing
// ****************************************
`define UART_CLK_HZ 100000000
`define UART_REF_HZ 2000000
`define UART_REF_DIV (`UART_CLK_HZ / `UART_REF_HZ)
`define UART_DATA_BITS 8
`define UART_FIFO_DEPTH 16

`endif

// File: core/card_uart_pkg.sv
// Types of the card debug serial port.
// Assumes nothing of its surroundings.
package card_uart_pkg;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;

endpackage

// File: core/uart_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    wrPtr_d = push ? wrPtr_q + AW'(1) : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + AW'(1) : rdPtr_q;
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + (AW+1)'(1);
    else if (pop && !push)
      count_d = count_q - (AW+1)'(1);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage has no reset; only pointers guard its contents
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end
endmodule
`default_nettype wire

// File: tb/serial_terminal_model.sv
// Terminal at the far end of the debug serial cable: sends 8N1 frames
// on the receive line and decodes frames seen on the transmit line.
// Assumes the shared 100 MHz clock; bit time is a whole number of cycles.
`timescale 1ns/1ps
`default_nettype none
module serial_terminal_model #(
  parameter int BIT_CLKS = 100
) (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic txLine,
  output logic rxLine,
  // Decoded character: stop bit above the data byte
  output logic gotStb,
  output logic [8:0] gotChar
);
  logic [8:0] shiftIn;

  initial
  begin
    rxLine = 1'b1;
    gotStb = 1'b0;
    gotChar = '0;
  end

  // ****************************************
  // Sender
  // ****************************************
  // A bad stop bit is cut short so its tail cannot pass for a new start
  task automatic send(input logic [7:0] b, input logic stopBit);
    logic [9:0] frm;
    frm = {stopBit, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      #1 rxLine = frm[i];
      repeat ((i == 9 && !stopBit) ? BIT_CLKS * 3 / 4 : BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    #1 rxLine = 1'b1;
  endtask

  // ****************************************
  // Receiver
  // ****************************************
  // The start bit may be short by half a bit, so sampling sits a quarter to three quarters of a bit into each bit
  always
  begin
    @(negedge txLine);
    repeat (BIT_CLKS + BIT_CLKS / 2 - 25) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      #1 shiftIn[i] = txLine;
      if (i < 8)
        repeat (BIT_CLKS) @(posedge clk);
    end
    gotChar = shiftIn;
    gotStb = 1'b1;
    @(posedge clk);
    #1 gotStb = 1'b0;
  end
endmodule
`default_nettype wire

// File: tb/card_debug_uart_tb.sv
// Self-checking bench of the card debug serial port.
// Assumes the terminal model on the serial lines and divisor 2 (100 cycles a bit).
`timescale 1ns/1ps
`default_nettype none
`include "card_uart_defs.svh"
module card_debug_uart_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [23:0] regAddr = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regWrData = '0;
  logic [7:0] regRdData;
  logic txReady;
  logic txLine;
  logic rxLine;
  logic gotStb;
  logic [8:0] gotChar;
  logic rdSeen = 1'b0;
  logic [7:0] b;
  logic [7:0] expRd[$];
  logic [8:0] expTx[$];
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int accepted = 0;

  always #5 clk = ~clk;

  card_debug_uart dut (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .txReady(txReady),
    .txLine(txLine), .rxLine(rxLine));

  serial_terminal_model #(.BIT_CLKS(100)) term (.clk(clk), .txLine(txLine), .rxLine(rxLine),
    .gotStb(gotStb), .gotChar(gotChar));

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input string what, input logic [8:0] expV, input logic [8:0] gotV);
    comparisons++;
    if (gotV !== expV)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, expV, gotV);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data stands from the edge after the read, so it is taken one edge later
  always @(posedge clk)
  begin
    if (rdSeen && expRd.size() > 0)
      check("regRdData", {1'b0, expRd.pop_front()}, {1'b0, regRdData});
    rdSeen <= regRdEn;
    if (gotStb === 1'b1)
      check("txLine char", expTx.size() > 0 ? expTx.pop_front() : 9'h000, gotChar);
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      close_out();
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #1 regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [23:0] a, input logic [7:0] expV);
    @(posedge clk);
    #1 regAddr = a;
    regRdEn = 1'b1;
    expRd.push_back(expV);
    @(posedge clk);
    #1 regRdEn = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(47673));
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    check("txLine idle", 9'h001, {8'h00, txLine});
    rd(`UART_ADDR_RATE, 8'hD0);
    rd(`UART_ADDR_CTRL, 8'h00);
    rd(24'h04004B, 8'h00);
    wr(`UART_ADDR_CTRL, 8'hFF);
    rd(`UART_ADDR_CTRL, 8'hC0);
    wr(`UART_ADDR_CTRL, 8'h40);
    rd(`UART_ADDR_CTRL, 8'h40);
    wr(`UART_ADDR_CTRL, 8'h00);
    wr(`UART_ADDR_RATE, 8'h02);
    rd(`UART_ADDR_RATE, 8'h02);
    // Fill the transmit queue until it refuses, then offer one byte too many
    while (txReady === 1'b1 && accepted < 40)
    begin
      b = 8'($urandom);
      wr(`UART_ADDR_DATA, b);
      expTx.push_back({1'b1, b});
      accepted++;
    end
    check("txReady full", 9'h000, {8'h00, txReady});
    wr(`UART_ADDR_DATA, 8'hA5);
    check("bytes taken", 9'h001, {8'h00, accepted == `UART_FIFO_DEPTH + 1});
    rd(`UART_ADDR_CTRL, 8'h01);
    while (expTx.size() > 0)
      @(posedge clk);
    repeat (1200) @(posedge clk);
    check("txReady drained", 9'h001, {8'h00, txReady});
    rd(`UART_ADDR_CTRL, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      b = 8'($urandom);
      term.send(b, 1'b1);
      repeat (60) @(posedge clk);
      rd(`UART_ADDR_CTRL, 8'h02);
      rd(`UART_ADDR_DATA, b);
      rd(`UART_ADDR_CTRL, 8'h00);
    end
    term.send(~b, 1'b0);
    repeat (60) @(posedge clk);
    rd(`UART_ADDR_CTRL, 8'h00);
    rd(`UART_ADDR_DATA, b);
    repeat (5) @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
